// ---- pkg/cbox_perf_pkg.sv ----
// constants and types shared by the slice event counter design
package cbox_perf_pkg;

    // --------------------------------
    // sizes
    // --------------------------------
    localparam int unsigned NUM_CTRS   = 2;
    localparam int unsigned CNT_W      = 32;
    localparam int unsigned TRK_DEPTH  = 16;
    localparam int unsigned TRK_ID_W   = 4;
    localparam int unsigned OCC_W      = 5;
    localparam int unsigned INC_W      = 5;
    localparam int unsigned RESP_KINDS = 5;

    // --------------------------------
    // register byte offsets
    // --------------------------------
    localparam logic [7:0] OFS_CTL0   = 8'h00;
    localparam logic [7:0] OFS_CTL1   = 8'h04;
    localparam logic [7:0] OFS_CNT0   = 8'h08;
    localparam logic [7:0] OFS_CNT1   = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_OCCUP  = 8'h14;

    // --------------------------------
    // field positions and reset values
    // --------------------------------
    localparam int unsigned CTL_EVT_LSB   = 0;
    localparam int unsigned CTL_UMASK_LSB = 8;
    localparam int unsigned CTL_EN_BIT    = 22;
    localparam int unsigned OCC_OUT_LSB   = 0;
    localparam int unsigned OCC_COH_LSB   = 8;
    localparam logic [31:0] CTL_RST       = 32'h0000_0000;
    localparam logic [31:0] CNT_RST       = 32'h0000_0000;

    // --------------------------------
    // event codes and unit-mask bits
    // --------------------------------
    localparam logic [7:0] EVT_SNOOP_RESP = 8'h22;
    localparam logic [7:0] EVT_LOOKUP     = 8'h34;
    localparam logic [7:0] EVT_OUT_OCC    = 8'h80;
    localparam logic [7:0] EVT_OUT_ALLOC  = 8'h81;
    localparam logic [7:0] EVT_COH_OCC    = 8'h83;
    localparam logic [7:0] EVT_COH_ALLOC  = 8'h84;
    localparam logic [7:0] UM_ALL         = 8'h01;
    localparam logic [7:0] UM_WRITES      = 8'h20;
    localparam logic [7:0] UM_EVICTS      = 8'h80;
    localparam int unsigned UM_SNP_FLT_LSB = 5;
    localparam int unsigned UM_LKP_FLT_LSB = 4;

    // --------------------------------
    // bus encodings and types
    // --------------------------------
    localparam logic       HRESP_OKAY = 1'b0;
    typedef enum logic [1:0] {
        LINE_M = 2'b00,
        LINE_E = 2'b01,
        LINE_S = 2'b10,
        LINE_I = 2'b11
    } line_state_t;
    typedef enum logic {
        PH_IDLE = 1'b0,
        PH_DATA = 1'b1
    } bus_phase_t;

endpackage

// ---- verilog/cbox_event_select.sv ----
// per-counter event selection: unit-mask filtering into a cycle increment
`timescale 1ns/10ps
`default_nettype none
module cbox_event_select
    import cbox_perf_pkg::*;
#(
    parameter bit IS_CTR0 = 1'b0
) (
    // selection
    input  wire logic [7:0]            evt_code,
    input  wire logic [7:0]            umask,
    // snoop responses
    input  wire logic                  snp_valid,
    input  wire logic [RESP_KINDS-1:0] snp_resp,
    input  wire logic                  snp_ext_req,
    input  wire logic                  snp_core_req,
    input  wire logic                  snp_evict,
    // lookups
    input  wire logic                  lkp_valid,
    input  wire logic [1:0]            lkp_state,
    input  wire logic                  lkp_core_rd,
    input  wire logic                  lkp_core_wr,
    input  wire logic                  lkp_ext_snp,
    // trackers
    input  wire logic [OCC_W-1:0]      out_occ,
    input  wire logic                  out_alloc,
    input  wire logic                  out_alloc_wr,
    input  wire logic                  out_alloc_evict,
    input  wire logic [OCC_W-1:0]      coh_occ,
    input  wire logic                  coh_alloc,
    // result
    output logic      [INC_W-1:0]      inc
);

    logic       snp_hit;
    logic       lkp_hit;
    logic [3:0] state_1h;
    logic [2:0] snp_flt;
    logic [3:0] lkp_flt;

    always_comb begin
        state_1h = 4'h0;
        state_1h[lkp_state] = 1'b1;
        snp_flt = {snp_evict, snp_core_req, snp_ext_req};
        // any queue source: every lookup qualifies
        lkp_flt = {1'b1, lkp_ext_snp, lkp_core_wr, lkp_core_rd};
        // union of response kinds, gated by any chosen filter
        // no filter chosen means nothing is counted
        snp_hit = snp_valid
                & (|(umask[RESP_KINDS-1:0] & snp_resp))
                & (|(umask[7:UM_SNP_FLT_LSB] & snp_flt));
        // union of line states, gated by any chosen source
        lkp_hit = lkp_valid
                & (|(umask[3:0] & state_1h))
                & (|(umask[7:UM_LKP_FLT_LSB] & lkp_flt));
        inc = '0;
        case (evt_code)
            EVT_SNOOP_RESP: inc = INC_W'(snp_hit);
            EVT_LOOKUP:     inc = INC_W'(lkp_hit);
            EVT_OUT_OCC: begin
                // occupancy weights only on counter 0
                if (IS_CTR0 && umask == UM_ALL) begin
                    inc = out_occ;
                end
            end
            EVT_OUT_ALLOC: begin
                // evictions are write entries too
                inc = INC_W'(out_alloc && ((umask & UM_ALL) != 8'h00
                    || ((umask & UM_WRITES) != 8'h00
                        && (out_alloc_wr || out_alloc_evict))
                    || ((umask & UM_EVICTS) != 8'h00 && out_alloc_evict)));
            end
            EVT_COH_OCC: begin
                if (IS_CTR0 && umask == UM_ALL) begin
                    inc = coh_occ;
                end
            end
            EVT_COH_ALLOC: begin
                inc = INC_W'(umask == UM_ALL && coh_alloc);
            end
            default: inc = '0;
        endcase
    end

endmodule // cbox_event_select
`default_nettype wire

// ---- verilog/cbox_perf_counters.sv ----
// slice event counters with tracker occupancy and AHB-Lite register slave
//
// Behaviour
// - snoop event counts chosen response kinds
// - external-snoop filter needs a response kind
// - core-request filter needs a response kind
// - eviction filter needs a response kind
// - lookup event counts chosen line states
// - core read filter needs a line state
// - core write filter needs a line state
// - external snoop filter needs a line state
// - any-source filter needs a line state
// - outgoing occupancy added every cycle
// - entry valid until first completion; counter 0
// - outgoing allocations counted once each
// - write allocations counted, including evictions
// - eviction allocations counted once each
// - coherent occupancy added per cycle; counter 0
// - coherent allocations counted once each
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module cbox_perf_counters
    import cbox_perf_pkg::*;
(
    // clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // snoop responses seen by the slice
    input  wire logic                  snp_valid,
    input  wire logic [RESP_KINDS-1:0] snp_resp,
    input  wire logic                  snp_ext_req,
    input  wire logic                  snp_core_req,
    input  wire logic                  snp_evict,
    // cache lookups
    input  wire logic                  lkp_valid,
    input  wire logic [1:0]            lkp_state,
    input  wire logic                  lkp_core_rd,
    input  wire logic                  lkp_core_wr,
    input  wire logic                  lkp_ext_snp,
    // outgoing tracker
    input  wire logic                  out_alloc,
    input  wire logic [TRK_ID_W-1:0]   out_alloc_id,
    input  wire logic                  out_alloc_wr,
    input  wire logic                  out_alloc_evict,
    input  wire logic                  completion_msg_a,
    input  wire logic [TRK_ID_W-1:0]   completion_msg_a_id,
    input  wire logic                  completion_msg_b,
    input  wire logic [TRK_ID_W-1:0]   completion_msg_b_id,
    // coherent tracker
    input  wire logic                  coh_alloc,
    input  wire logic [TRK_ID_W-1:0]   coh_alloc_id,
    input  wire logic                  coh_free,
    input  wire logic [TRK_ID_W-1:0]   coh_free_id
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    bus_phase_t            phase_ff;
    logic                  wr_pend_ff;
    logic [7:0]            addr_ff;
    logic [31:0]           hrdata_ff;
    logic                  hreadyout_ff;
    logic                  hresp_ff;
    logic [31:0]           ctl_ff   [NUM_CTRS];
    logic [CNT_W-1:0]      cnt_ff   [NUM_CTRS];
    logic [NUM_CTRS-1:0]   ovf_ff;
    logic [TRK_DEPTH-1:0]  out_vld_ff;
    logic [TRK_DEPTH-1:0]  coh_vld_ff;
    logic [OCC_W-1:0]      out_occ;
    logic [OCC_W-1:0]      coh_occ;
    logic [INC_W-1:0]      inc      [NUM_CTRS];
    logic                  addr_take;
    logic                  wr_now;
    logic [31:0]           nxt_rdata;
    logic [NUM_CTRS-1:0]   wrap;
    logic [NUM_CTRS-1:0]   ovf_clr;

    // ----------------------------------------------------------------
    // bus address phase and data phase
    // ----------------------------------------------------------------
    // zero-wait slave: hready low comes from this block only in reset and until the
    // first clock edge after it; a stalled address phase from another slave is still honoured
    assign addr_take = hsel & hready & htrans[1];
    assign wr_now    = (phase_ff == PH_DATA) & wr_pend_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_ff   <= PH_IDLE;
            wr_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
        end else if (hready) begin
            phase_ff   <= addr_take ? PH_DATA : PH_IDLE;
            wr_pend_ff <= addr_take & hwrite;
            addr_ff    <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b0;
            hresp_ff     <= HRESP_OKAY;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= HRESP_OKAY;
        end
    end

    // ----------------------------------------------------------------
    // read mux: sampled at the address-phase edge
    // ----------------------------------------------------------------
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (haddr[7:0])
            OFS_CTL0:   nxt_rdata = ctl_ff[0];
            OFS_CTL1:   nxt_rdata = ctl_ff[1];
            OFS_CNT0:   nxt_rdata = cnt_ff[0];
            OFS_CNT1:   nxt_rdata = cnt_ff[1];
            OFS_STATUS: nxt_rdata = {{(32-NUM_CTRS){1'b0}}, ovf_ff};
            OFS_OCCUP: begin
                nxt_rdata[OCC_OUT_LSB +: OCC_W] = out_occ;
                nxt_rdata[OCC_COH_LSB +: OCC_W] = coh_occ;
            end
            default:    nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata_ff <= nxt_rdata;
        end
    end

    // ----------------------------------------------------------------
    // tracker entry valid bits
    // ----------------------------------------------------------------
    // an entry leaves occupancy on whichever completion message comes
    // first; the later one finds it already clear and does nothing
    for (genvar e = 0; e < TRK_DEPTH; e++) begin : g_trk
        logic out_set;
        logic out_clr;
        logic coh_set;
        logic coh_clr;
        assign out_set = out_alloc && out_alloc_id == TRK_ID_W'(e);
        assign out_clr = (completion_msg_a
                          && completion_msg_a_id == TRK_ID_W'(e))
                       || (completion_msg_b
                          && completion_msg_b_id == TRK_ID_W'(e));
        assign coh_set = coh_alloc && coh_alloc_id == TRK_ID_W'(e);
        assign coh_clr = coh_free && coh_free_id == TRK_ID_W'(e);

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                out_vld_ff[e] <= 1'b0;
            end else if (out_set) begin
                out_vld_ff[e] <= 1'b1;
            end else if (out_clr) begin
                out_vld_ff[e] <= 1'b0;
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                coh_vld_ff[e] <= 1'b0;
            end else if (coh_set) begin
                coh_vld_ff[e] <= 1'b1;
            end else if (coh_clr) begin
                coh_vld_ff[e] <= 1'b0;
            end
        end
    end

    // population counts of valid entries
    always_comb begin
        out_occ = '0;
        coh_occ = '0;
        for (int i = 0; i < TRK_DEPTH; i++) begin
            out_occ = out_occ + OCC_W'(out_vld_ff[i]);
            coh_occ = coh_occ + OCC_W'(coh_vld_ff[i]);
        end
    end

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    for (genvar c = 0; c < NUM_CTRS; c++) begin : g_ctr
        logic [CNT_W:0] sum;
        logic           ctl_hit;
        logic           cnt_hit;

        assign ctl_hit = wr_now && addr_ff == (OFS_CTL0 + 8'(4 * c));
        assign cnt_hit = wr_now && addr_ff == (OFS_CNT0 + 8'(4 * c));
        assign sum     = {1'b0, cnt_ff[c]} + (CNT_W + 1)'(inc[c]);
        assign wrap[c] = ctl_ff[c][CTL_EN_BIT] & !cnt_hit & sum[CNT_W];

        cbox_event_select #(
            .IS_CTR0 (c == 0)
        ) u_sel (
            .evt_code        (ctl_ff[c][CTL_EVT_LSB +: 8]),
            .umask           (ctl_ff[c][CTL_UMASK_LSB +: 8]),
            .snp_valid       (snp_valid),
            .snp_resp        (snp_resp),
            .snp_ext_req     (snp_ext_req),
            .snp_core_req    (snp_core_req),
            .snp_evict       (snp_evict),
            .lkp_valid       (lkp_valid),
            .lkp_state       (lkp_state),
            .lkp_core_rd     (lkp_core_rd),
            .lkp_core_wr     (lkp_core_wr),
            .lkp_ext_snp     (lkp_ext_snp),
            .out_occ         (out_occ),
            .out_alloc       (out_alloc),
            .out_alloc_wr    (out_alloc_wr),
            .out_alloc_evict (out_alloc_evict),
            .coh_occ         (coh_occ),
            .coh_alloc       (coh_alloc),
            .inc             (inc[c])
        );

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ctl_ff[c] <= CTL_RST;
            end else if (ctl_hit) begin
                ctl_ff[c] <= hwdata;
            end
        end

        // a software write to the count wins over that cycle's event
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cnt_ff[c] <= CNT_RST;
            end else if (cnt_hit) begin
                cnt_ff[c] <= hwdata;
            end else if (ctl_ff[c][CTL_EN_BIT]) begin
                cnt_ff[c] <= sum[CNT_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // overflow flags: write one to clear, a new wrap wins
    // ----------------------------------------------------------------
    assign ovf_clr = (wr_now && addr_ff == OFS_STATUS)
                   ? hwdata[NUM_CTRS-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_ff <= '0;
        end else begin
            ovf_ff <= (ovf_ff & ~ovf_clr) | wrap;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata    = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp     = hresp_ff;

endmodule // cbox_perf_counters
`default_nettype wire

// ---- sim/cbox_perf_counters_assertions.sv ----
// port checker for the slice event counters
`timescale 1ns/10ps
`default_nettype none
module cbox_perf_counters_checker
    import cbox_perf_pkg::*;
(
    // clock and reset
    input wire logic                hclk,
    input wire logic                hresetn,
    // bus
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic                hready,
    input wire logic [31:0]         hrdata,
    input wire logic                hreadyout,
    input wire logic                hresp,
    // trackers
    input wire logic                out_alloc,
    input wire logic [TRK_ID_W-1:0] out_alloc_id,
    input wire logic                completion_msg_a,
    input wire logic [TRK_ID_W-1:0] completion_msg_a_id,
    input wire logic                completion_msg_b,
    input wire logic [TRK_ID_W-1:0] completion_msg_b_id,
    input wire logic                coh_alloc,
    input wire logic [TRK_ID_W-1:0] coh_alloc_id,
    input wire logic                coh_free,
    input wire logic [TRK_ID_W-1:0] coh_free_id
);
    // --------------------------------
    // shadow of tracker valid bits, allocation wins over a free
    // --------------------------------
    logic [TRK_DEPTH-1:0] out_v_ff;
    logic [TRK_DEPTH-1:0] coh_v_ff;
    logic                 rd_take;
    assign rd_take = hsel & hready & htrans[1] & ~hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_v_ff <= '0;
            coh_v_ff <= '0;
        end else begin
            if (completion_msg_a) out_v_ff[completion_msg_a_id] <= 1'b0;
            if (completion_msg_b) out_v_ff[completion_msg_b_id] <= 1'b0;
            if (out_alloc) out_v_ff[out_alloc_id] <= 1'b1;
            if (coh_free) coh_v_ff[coh_free_id] <= 1'b0;
            if (coh_alloc) coh_v_ff[coh_alloc_id] <= 1'b1;
        end
    end
    // --------------------------------
    // properties
    // --------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_resp_okay; hresp == HRESP_OKAY; endproperty
    a_resp_okay: assert property (p_resp_okay)
        else $error("not okay");
    property p_ready; $past(hresetn) |-> hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("slave not ready");
    property p_rdata_hold;
        $past(hresetn) && !$past(rd_take) |-> $stable(hrdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved");
    property p_unmapped;
        rd_take && haddr[7:0] > 8'h17 |=> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
    property p_status_hi;
        rd_take && haddr[7:0] == OFS_STATUS |=> hrdata[31:2] == 30'h0;
    endproperty
    a_status_hi: assert property (p_status_hi) else $error("status high");
    property p_out_occ;
        rd_take && haddr[7:0] == OFS_OCCUP |=> hrdata[OCC_OUT_LSB +: OCC_W]
            == OCC_W'($countones($past(out_v_ff)));
    endproperty
    a_out_occ: assert property (p_out_occ)
        else $error("out occupancy");
    property p_coh_occ;
        rd_take && haddr[7:0] == OFS_OCCUP |=> hrdata[OCC_COH_LSB +: OCC_W]
            == OCC_W'($countones($past(coh_v_ff)));
    endproperty
    a_coh_occ: assert property (p_coh_occ)
        else $error("coh occupancy");
    property p_occ_hi;
        rd_take && haddr[7:0] == OFS_OCCUP |=> hrdata[31:13] == 19'h0;
    endproperty
    a_occ_hi: assert property (p_occ_hi) else $error("occupancy high");
    c_occ: cover property (rd_take && haddr[7:0] == OFS_OCCUP && |out_v_ff);
    c_free_b: cover property (completion_msg_b && |out_v_ff);
    c_coh: cover property (coh_alloc ##1 coh_free);
endmodule // cbox_perf_counters_checker
bind cbox_perf_counters cbox_perf_counters_checker checker_inst (.hclk,
    .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .out_alloc, .out_alloc_id, .completion_msg_a,
    .completion_msg_a_id, .completion_msg_b, .completion_msg_b_id,
    .coh_alloc, .coh_alloc_id, .coh_free, .coh_free_id);
`default_nettype wire

// ---- sim/cbox_perf_counters_bench.sv ----
// self-checking bench for the slice event counters
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    mismatches++; $display("unexpected at %0t: got %h expected %h", \
    $time, g, e); end end
module cbox_perf_counters_bench
    import cbox_perf_pkg::*;
;
    typedef struct packed {
        logic [7:0]  evt;
        logic [7:0]  um;
        logic        en;
        logic [18:0] ev;
        logic        n;
    } row_t;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire logic   hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [18:0] ev = 19'h0;
    logic [3:0]  aid = 4'h0;
    logic        ca = 1'b0;
    logic        cb = 1'b0;
    logic        cf = 1'b0;
    logic [3:0]  ca_id = 4'h0;
    logic [3:0]  cb_id = 4'h0;
    logic [3:0]  cf_id = 4'h0;
    logic [31:0] d;
    int unsigned mismatches = 0;
    int unsigned total_checks = 0;
    int unsigned cycles = 0;
    // ev: snoop valid, kind, ext, core, evict | lookup valid, state,
    // rd, wr, ext | out alloc, wr, evict | coherent alloc
    row_t rows [26] = '{
        '{8'h22, 8'h21, 1'b1, 19'h43000, 1'b1},
        '{8'h22, 8'h21, 1'b1, 19'h42000, 1'b0},
        '{8'h22, 8'h42, 1'b1, 19'h44800, 1'b1},
        '{8'h22, 8'h84, 1'b1, 19'h48400, 1'b1},
        '{8'h22, 8'h28, 1'b1, 19'h51000, 1'b1},
        '{8'h22, 8'h30, 1'b1, 19'h61000, 1'b1},
        '{8'h22, 8'h01, 1'b1, 19'h43000, 1'b0},
        '{8'h22, 8'h20, 1'b1, 19'h43000, 1'b0},
        '{8'h22, 8'h23, 1'b1, 19'h45000, 1'b1},
        '{8'h22, 8'h21, 1'b0, 19'h43000, 1'b0},
        '{8'h34, 8'h11, 1'b1, 19'h00240, 1'b1},
        '{8'h34, 8'h12, 1'b1, 19'h00240, 1'b0},
        '{8'h34, 8'h11, 1'b1, 19'h00220, 1'b0},
        '{8'h34, 8'h10, 1'b1, 19'h00240, 1'b0},
        '{8'h34, 8'h22, 1'b1, 19'h002A0, 1'b1},
        '{8'h34, 8'h44, 1'b1, 19'h00310, 1'b1},
        '{8'h34, 8'h88, 1'b1, 19'h003A0, 1'b1},
        '{8'h34, 8'h13, 1'b1, 19'h002C0, 1'b1},
        '{8'h81, 8'h01, 1'b1, 19'h00008, 1'b1},
        '{8'h81, 8'h20, 1'b1, 19'h0000C, 1'b1},
        '{8'h81, 8'h20, 1'b1, 19'h00008, 1'b0},
        '{8'h81, 8'h20, 1'b1, 19'h0000A, 1'b1},
        '{8'h81, 8'h80, 1'b1, 19'h0000A, 1'b1},
        '{8'h84, 8'h01, 1'b1, 19'h00001, 1'b1},
        '{8'h84, 8'h01, 1'b1, 19'h00008, 1'b0},
        '{8'h84, 8'h02, 1'b1, 19'h00001, 1'b0}
    };
    always #2 hclk = ~hclk;
    assign hready = hreadyout;
    cbox_perf_counters cbox_perf_counters_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .snp_valid(ev[18]), .snp_resp(ev[17:13]),
        .snp_ext_req(ev[12]), .snp_core_req(ev[11]), .snp_evict(ev[10]),
        .lkp_valid(ev[9]), .lkp_state(ev[8:7]), .lkp_core_rd(ev[6]),
        .lkp_core_wr(ev[5]), .lkp_ext_snp(ev[4]), .out_alloc(ev[3]),
        .out_alloc_id(aid), .out_alloc_wr(ev[2]), .out_alloc_evict(ev[1]),
        .completion_msg_a(ca), .completion_msg_a_id(ca_id),
        .completion_msg_b(cb), .completion_msg_b_id(cb_id),
        .coh_alloc(ev[0]), .coh_alloc_id(aid), .coh_free(cf),
        .coh_free_id(cf_id));
    // --------------------------------
    // bus and stimulus tasks
    // --------------------------------
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] x;
        bus(1'b1, a, wd, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus(1'b0, a, 32'h0, v);
    endtask
    task automatic pulse3(input logic [18:0] s);
        repeat (3) begin
            @(posedge hclk);
            ev <= s;
            aid <= aid + 4'h1;
        end
        @(posedge hclk);
        ev <= 19'h0;
    endtask
    // frees every entry of both trackers
    task automatic free_all();
        for (int i = 0; i < 16; i++) begin
            @(posedge hclk);
            ca <= 1'b1;
            ca_id <= 4'(i);
            cf <= 1'b1;
            cf_id <= 4'(i);
        end
        @(posedge hclk);
        ca <= 1'b0;
        cf <= 1'b0;
    endtask
    // two entries live five cycles each: 10 on counter 0
    task automatic occ_run(input logic coh);
        wr(OFS_CTL0, coh ? 32'h0040_0183 : 32'h0040_0180);
        wr(OFS_CTL1, coh ? 32'h0040_0183 : 32'h0040_0180);
        wr(OFS_CNT0, 32'h0);
        wr(OFS_CNT1, 32'h0);
        @(posedge hclk);
        ev <= coh ? 19'h1 : 19'h8;
        aid <= 4'h1;
        @(posedge hclk);
        aid <= 4'h2;
        @(posedge hclk);
        ev <= 19'h0;
        repeat (3) @(posedge hclk);
        ca <= 1'b1;
        ca_id <= 4'h1;
        cf <= 1'b1;
        cf_id <= 4'h1;
        @(posedge hclk);
        ca <= 1'b0;
        cb <= 1'b1;
        cb_id <= 4'h2;
        cf_id <= 4'h2;
        @(posedge hclk);
        cb <= 1'b0;
        cf <= 1'b0;
        wr(OFS_CTL0, 32'h0);
        wr(OFS_CTL1, 32'h0);
        rd(OFS_CNT0, d);
        `CHK(d, 32'hA)
        rd(OFS_CNT1, d);
        `CHK(d, 32'h0)
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            stop_test();
        end
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (int a = 0; a < 28; a += 4) begin
            rd(8'(a), d);
            `CHK(d, 32'h0)
        end
        wr(8'h18, 32'hFFFF_FFFF);
        rd(8'h18, d);
        `CHK(d, 32'h0)
        foreach (rows[i]) begin
            wr(OFS_CTL0, {9'h0, rows[i].en, 6'h0, rows[i].um, rows[i].evt});
            wr(OFS_CNT0, 32'h0);
            pulse3(rows[i].ev);
            wr(OFS_CTL0, 32'h0);
            rd(OFS_CNT0, d);
            `CHK(d, rows[i].n ? 32'h3 : 32'h0)
        end
        free_all();
        occ_run(1'b0);
        occ_run(1'b1);
        @(posedge hclk);
        ev <= 19'h9;
        aid <= 4'h5;
        @(posedge hclk);
        ev <= 19'h0;
        rd(OFS_OCCUP, d);
        `CHK(d, 32'h0000_0101)
        free_all();
        // counter 1 wraps on its first allocation
        wr(OFS_CTL1, 32'h0040_0181);
        wr(OFS_CNT1, 32'hFFFF_FFFF);
        pulse3(19'h8);
        wr(OFS_CTL1, 32'h0);
        rd(OFS_CNT1, d);
        `CHK(d, 32'h2)
        rd(OFS_STATUS, d);
        `CHK(d, 32'h2)
        wr(OFS_STATUS, 32'h2);
        rd(OFS_STATUS, d);
        `CHK(d, 32'h0)
        wr(OFS_CTL0, 32'h0040_2234);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(OFS_CTL0, d);
        `CHK(d, 32'h0)
        stop_test();
    end
endmodule // cbox_perf_counters_bench
`default_nettype wire
